// [anx_pkg.sv]
// constants shared by the negotiation transmit register bank and its dataplane
`default_nettype none

package anx_pkg;

    // =====================================================================
    // bus widths
    localparam int APB_DATA_W = 32;
    localparam int APB_ADDR_W = 10;
    localparam int REG_W = 8;
    localparam int PAGE_W = 48;
    localparam int PAGE_BYTES = 6;
    localparam int ACK_CNT_W = 4;

    // =====================================================================
    // address fields: group select and register offset
    localparam int GROUP_MSB = 9;
    localparam int GROUP_LSB = 6;
    localparam int OFFSET_MSB = 5;
    localparam int OFFSET_LSB = 2;

    // =====================================================================
    // group codes
    localparam logic [3:0] GRP_NEG_TX = 4'h0;
    localparam logic [3:0] GRP_NEG_RX = 4'h1;
    localparam logic [3:0] GRP_TRAIN_TX = 4'h2;
    localparam logic [3:0] GRP_TRAIN_RX = 4'h3;
    localparam logic [3:0] GRP_TX_CTRL = 4'h8;
    localparam logic [3:0] GRP_RX_CTRL = 4'h9;
    localparam logic [3:0] GRP_MAC_TX_CFG = 4'ha;
    localparam logic [3:0] GRP_MAC_RX_CFG = 4'hb;
    localparam logic [3:0] GRP_MAC_TX_STAT = 4'hc;
    localparam logic [3:0] GRP_MAC_RX_STAT = 4'hd;

    // =====================================================================
    // register offsets inside the negotiation transmit group
    localparam logic [3:0] OFS_MAIN_CONTROL = 4'h0;
    localparam logic [3:0] OFS_ACK_CONTROL = 4'h1;
    localparam logic [3:0] OFS_EXTERNAL_CONFIG = 4'h2;
    localparam logic [3:0] OFS_RESERVED = 4'h3;
    localparam logic [3:0] OFS_PAGE_BYTE0 = 4'h8;
    localparam logic [3:0] OFS_PAGE_BYTE5 = 4'hd;

    // =====================================================================
    // field positions
    localparam int BIT_DP_RESET = 7;
    localparam int BIT_PAGE_READY = 0;
    localparam int BIT_ACK_ON = 4;
    localparam int ACK_CNT_MSB = 3;
    localparam int BIT_LINK_DISCONNECT = 7;
    localparam int BIT_TENGIG_MODE = 2;
    localparam int BIT_PAUSE_PORT = 0;

    // =====================================================================
    // reset values
    localparam logic RST_BIT = 1'b0;
    localparam logic [REG_W-1:0] RST_BYTE = 8'h00;
    localparam logic [ACK_CNT_W-1:0] RST_ACK_CNT = 4'h0;
    localparam logic [APB_DATA_W-1:0] RST_WORD = 32'h0000_0000;

endpackage

`default_nettype wire

// [anx_tx_dataplane.sv]
// transmit dataplane page handoff and ack insertion counter
`default_nettype none

module anx_tx_dataplane #(
    parameter int PAGE_W = anx_pkg::PAGE_W,
    parameter int ACK_CNT_W = anx_pkg::ACK_CNT_W
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic dp_reset,
    input wire logic page_ready,
    input wire logic [PAGE_W-1:0] page_in,
    input wire logic ack_on,
    input wire logic [ACK_CNT_W-1:0] ack_cnt,
    input wire logic frame_sent,
    output logic page_taken,
    output logic ack_done,
    output logic [PAGE_W-1:0] tx_page,
    output logic tx_ack_insert
);

    // =====================================================================
    // handoff detection
    logic page_ready_d;
    logic [ACK_CNT_W-1:0] ack_left;
    logic start;

    // only a low-to-high move of the flag starts a page; a flag that stays
    // high is the same page and must not be copied twice
    assign start = page_ready & ~page_ready_d;

    // previous flag value, cleared under dataplane reset so a pending page
    // is picked up as soon as the reset is lifted
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            page_ready_d <= anx_pkg::RST_BIT;
        end else if (dp_reset) begin
            page_ready_d <= anx_pkg::RST_BIT;
        end else begin
            page_ready_d <= page_ready;
        end
    end

    // page copy into the holding register and one-cycle acknowledge
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            tx_page <= '0;
            page_taken <= anx_pkg::RST_BIT;
        end else if (dp_reset) begin
            tx_page <= '0;
            page_taken <= anx_pkg::RST_BIT;
        end else begin
            page_taken <= start;
            if (start) begin
                tx_page <= page_in;
            end
        end
    end

    // =====================================================================
    // ack insertion: enable sampled at page start, count is frames minus one
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            tx_ack_insert <= anx_pkg::RST_BIT;
            ack_left <= anx_pkg::RST_ACK_CNT;
            ack_done <= anx_pkg::RST_BIT;
        end else if (dp_reset) begin
            tx_ack_insert <= anx_pkg::RST_BIT;
            ack_left <= anx_pkg::RST_ACK_CNT;
            ack_done <= anx_pkg::RST_BIT;
        end else begin
            ack_done <= anx_pkg::RST_BIT;
            if (start) begin
                tx_ack_insert <= ack_on;
                ack_left <= ack_cnt;
            end else if (tx_ack_insert && frame_sent) begin
                if (ack_left == '0) begin
                    tx_ack_insert <= anx_pkg::RST_BIT;
                    ack_done <= 1'b1;
                end else begin
                    ack_left <= ack_left - 1'b1;
                end
            end
        end
    end

endmodule

`default_nettype wire

// [anx_apb_regs.sv]
// apb register bank for the negotiation transmit group with group decode
`default_nettype none

module anx_apb_regs #(
    parameter int ADDR_W = anx_pkg::APB_ADDR_W,
    parameter int DATA_W = anx_pkg::APB_DATA_W,
    parameter int PAGE_W = anx_pkg::PAGE_W,
    parameter int ACK_CNT_W = anx_pkg::ACK_CNT_W
) (
    input wire logic clk_sys,
    input wire logic rstn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    output logic [DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // accesses to groups decoded here but served elsewhere
    output logic ext_access,
    output logic ext_write,
    output logic [3:0] ext_group,
    output logic [3:0] ext_offset,
    output logic [DATA_W-1:0] ext_wdata,
    // transmit dataplane
    input wire logic frame_sent,
    output logic dp_reset,
    output logic [PAGE_W-1:0] tx_page,
    output logic tx_ack_insert,
    output logic link_disconnect,
    output logic tengig_mode_select,
    output logic pause_capable
);

    // =====================================================================
    // address decode
    logic [3:0] addr_group;
    logic [3:0] addr_offset;
    logic grp_neg_tx;
    logic grp_known;
    logic setup_phase;
    logic wr_commit;
    logic neg_tx_wr;

    assign addr_group = paddr[anx_pkg::GROUP_MSB:anx_pkg::GROUP_LSB];
    assign addr_offset = paddr[anx_pkg::OFFSET_MSB:anx_pkg::OFFSET_LSB];
    assign grp_neg_tx = (addr_group == anx_pkg::GRP_NEG_TX);

    // the group map has a hole from 0x4 to 0x7 and nothing above 0xd;
    // accesses there answer with an error instead of silently aliasing
    always_comb begin
        case (addr_group)
            anx_pkg::GRP_NEG_TX,
            anx_pkg::GRP_NEG_RX,
            anx_pkg::GRP_TRAIN_TX,
            anx_pkg::GRP_TRAIN_RX,
            anx_pkg::GRP_TX_CTRL,
            anx_pkg::GRP_RX_CTRL,
            anx_pkg::GRP_MAC_TX_CFG,
            anx_pkg::GRP_MAC_RX_CFG,
            anx_pkg::GRP_MAC_TX_STAT,
            anx_pkg::GRP_MAC_RX_STAT: begin
                grp_known = 1'b1;
            end
            default: begin
                grp_known = 1'b0;
            end
        endcase
    end

    // the slave answers with one wait-free access phase: pready rises from
    // the setup cycle, so writes commit at the end of the access cycle
    assign setup_phase = psel & ~penable;
    assign wr_commit = psel & penable & pwrite & pready;
    assign neg_tx_wr = wr_commit & grp_neg_tx;

    // =====================================================================
    // register storage
    logic page_ready;
    logic ack_on;
    logic [ACK_CNT_W-1:0] ack_cnt;
    logic [anx_pkg::REG_W-1:0] page_byte [anx_pkg::PAGE_BYTES];
    logic [PAGE_W-1:0] page_flat;
    logic page_taken;
    logic ack_done;
    logic page_byte_hit;
    logic [2:0] page_index;

    // page bytes live at consecutive offsets, lowest byte first
    assign page_byte_hit = (addr_offset >= anx_pkg::OFS_PAGE_BYTE0) &&
                           (addr_offset <= anx_pkg::OFS_PAGE_BYTE5);
    assign page_index = 3'(addr_offset - anx_pkg::OFS_PAGE_BYTE0);

    // flatten the byte array into the page handed to the dataplane
    always_comb begin
        page_flat = '0;
        for (int i = 0; i < anx_pkg::PAGE_BYTES; i++) begin
            page_flat[i*anx_pkg::REG_W +: anx_pkg::REG_W] = page_byte[i];
        end
    end

    // dataplane reset: plain read/write bit, the bus side never sees it
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            dp_reset <= anx_pkg::RST_BIT;
        end else if (neg_tx_wr && addr_offset == anx_pkg::OFS_MAIN_CONTROL) begin
            dp_reset <= pwdata[anx_pkg::BIT_DP_RESET];
        end
    end

    // page handoff flag: a written one wins over a same-cycle copy acknowledge,
    // so the flag stays high, but with no new rise the dataplane never copies that page; writing zero has no effect
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            page_ready <= anx_pkg::RST_BIT;
        end else if (neg_tx_wr && addr_offset == anx_pkg::OFS_MAIN_CONTROL &&
                     pwdata[anx_pkg::BIT_PAGE_READY]) begin
            page_ready <= 1'b1;
        end else if (page_taken) begin
            page_ready <= 1'b0;
        end
    end

    // ack enable: software set wins over the completion clear
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ack_on <= anx_pkg::RST_BIT;
        end else if (neg_tx_wr && addr_offset == anx_pkg::OFS_ACK_CONTROL) begin
            ack_on <= pwdata[anx_pkg::BIT_ACK_ON] | (ack_on & ~ack_done);
        end else if (ack_done) begin
            ack_on <= 1'b0;
        end
    end

    // ack count: contents undefined at reset, cleared here to keep x out
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ack_cnt <= anx_pkg::RST_ACK_CNT;
        end else if (neg_tx_wr && addr_offset == anx_pkg::OFS_ACK_CONTROL) begin
            ack_cnt <= pwdata[anx_pkg::ACK_CNT_MSB:0];
        end
    end

    // external configuration bits
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            link_disconnect <= anx_pkg::RST_BIT;
            tengig_mode_select <= anx_pkg::RST_BIT;
            pause_capable <= anx_pkg::RST_BIT;
        end else if (neg_tx_wr && addr_offset == anx_pkg::OFS_EXTERNAL_CONFIG) begin
            link_disconnect <= pwdata[anx_pkg::BIT_LINK_DISCONNECT];
            tengig_mode_select <= pwdata[anx_pkg::BIT_TENGIG_MODE];
            pause_capable <= pwdata[anx_pkg::BIT_PAUSE_PORT];
        end
    end

    // page bytes; rewriting while the flag is high is the software's hazard,
    // the dataplane has only copied the page once the flag drops
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < anx_pkg::PAGE_BYTES; i++) begin
                page_byte[i] <= anx_pkg::RST_BYTE;
            end
        end else if (neg_tx_wr && page_byte_hit) begin
            page_byte[page_index] <= pwdata[anx_pkg::REG_W-1:0];
        end
    end

    // =====================================================================
    // read mux: unlisted bits and offset 3 read as zero
    logic [DATA_W-1:0] next_prdata;

    always_comb begin
        next_prdata = anx_pkg::RST_WORD;
        if (grp_neg_tx) begin
            case (addr_offset)
                anx_pkg::OFS_MAIN_CONTROL: begin
                    next_prdata[anx_pkg::BIT_DP_RESET] = dp_reset;
                    next_prdata[anx_pkg::BIT_PAGE_READY] = page_ready;
                end
                anx_pkg::OFS_ACK_CONTROL: begin
                    next_prdata[anx_pkg::BIT_ACK_ON] = ack_on;
                    next_prdata[anx_pkg::ACK_CNT_MSB:0] = ack_cnt;
                end
                anx_pkg::OFS_EXTERNAL_CONFIG: begin
                    next_prdata[anx_pkg::BIT_LINK_DISCONNECT] = link_disconnect;
                    next_prdata[anx_pkg::BIT_TENGIG_MODE] = tengig_mode_select;
                    next_prdata[anx_pkg::BIT_PAUSE_PORT] = pause_capable;
                end
                anx_pkg::OFS_RESERVED: begin
                    next_prdata = anx_pkg::RST_WORD;
                end
                default: begin
                    if (page_byte_hit) begin
                        next_prdata[anx_pkg::REG_W-1:0] = page_byte[page_index];
                    end
                end
            endcase
        end
    end

    // =====================================================================
    // apb response: data and error captured in the setup cycle
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            pready <= anx_pkg::RST_BIT;
            pslverr <= anx_pkg::RST_BIT;
            prdata <= anx_pkg::RST_WORD;
        end else begin
            pready <= setup_phase;
            pslverr <= setup_phase & ~grp_known;
            if (setup_phase) begin
                prdata <= pwrite ? anx_pkg::RST_WORD : next_prdata;
            end
        end
    end

    // strobe for the groups whose contents are kept by other blocks
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ext_access <= anx_pkg::RST_BIT;
            ext_write <= anx_pkg::RST_BIT;
            ext_group <= anx_pkg::GRP_NEG_TX;
            ext_offset <= anx_pkg::OFS_MAIN_CONTROL;
            ext_wdata <= anx_pkg::RST_WORD;
        end else begin
            ext_access <= setup_phase & grp_known & ~grp_neg_tx;
            if (setup_phase) begin
                ext_write <= pwrite;
                ext_group <= addr_group;
                ext_offset <= addr_offset;
                ext_wdata <= pwdata;
            end
        end
    end

    // =====================================================================
    // transmit dataplane
    anx_tx_dataplane #(
        .PAGE_W(PAGE_W),
        .ACK_CNT_W(ACK_CNT_W)
    ) u_dataplane (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .dp_reset(dp_reset),
        .page_ready(page_ready),
        .page_in(page_flat),
        .ack_on(ack_on),
        .ack_cnt(ack_cnt),
        .frame_sent(frame_sent),
        .page_taken(page_taken),
        .ack_done(ack_done),
        .tx_page(tx_page),
        .tx_ack_insert(tx_ack_insert)
    );

endmodule

`default_nettype wire

// [anx_apb_regs_properties.sv]
// concurrent checks on the ports of the negotiation transmit register bank
`default_nettype none

module anx_regs_chk #(
    parameter int ADDR_W = 10,
    parameter int DATA_W = 32
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    input wire logic [DATA_W-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic ext_access,
    input wire logic [3:0] ext_group,
    input wire logic [3:0] ext_offset,
    input wire logic dp_reset,
    input wire logic link_disconnect,
    input wire logic tengig_mode_select,
    input wire logic pause_capable
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);

    // =====================================================================
    // decode helpers
    logic setup, wacc, bad, ext, loc;
    logic [ADDR_W-1:0] addr_q;
    logic [DATA_W-1:0] wdata_q;
    assign setup = psel && !penable;
    assign wacc = psel && penable && pready && pwrite;
    assign bad = paddr[9:6] inside {[4'h4:4'h7], [4'he:4'hf]};
    assign loc = paddr[9:6] == 4'h0;
    assign ext = !bad && !loc;

    // captured bus fields, so the checks compare against the request itself
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            addr_q <= '0;
            wdata_q <= '0;
        end else begin
            addr_q <= paddr;
            wdata_q <= pwdata;
        end
    end

    // =====================================================================
    // bus timing and decode
    a_ready_after_setup: assert property (setup |=> pready)
        else $error("pready missing after setup");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("pready held too long");
    a_err_unmapped: assert property (setup && bad |=> pslverr)
        else $error("no error for unmapped group");
    a_ok_mapped: assert property (setup && !bad |=> !pslverr)
        else $error("error on mapped group");
    a_ext_fields: assert property (
        setup && ext |=> ext_access && ext_group == addr_q[9:6] && ext_offset == addr_q[5:2])
        else $error("forwarded access fields wrong");
    a_ext_quiet: assert property (setup && !ext |=> !ext_access)
        else $error("local access forwarded");

    // =====================================================================
    // control fields
    a_dp_reset_write: assert property (
        wacc && loc && paddr[5:2] == 4'h0 |=> dp_reset == wdata_q[7])
        else $error("dataplane reset not written");
    a_cfg_write: assert property (
        wacc && loc && paddr[5:2] == 4'h2 |=> {link_disconnect, tengig_mode_select,
        pause_capable} == {wdata_q[7], wdata_q[2], wdata_q[0]})
        else $error("config outputs not written");
    a_upper_zero: assert property (
        setup && loc && !pwrite |=> prdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    a_reserved_zero: assert property (
        setup && loc && paddr[5:2] == 4'h3 |=> prdata == 32'h0)
        else $error("reserved offset not zero");
endmodule

bind anx_apb_regs anx_regs_chk #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_chk (
    .clk_sys(clk_sys), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_access(ext_access), .ext_group(ext_group), .ext_offset(ext_offset),
    .dp_reset(dp_reset), .link_disconnect(link_disconnect),
    .tengig_mode_select(tengig_mode_select), .pause_capable(pause_capable));

`default_nettype wire

// [anx_apb_master.sv]
// apb master model standing in for the negotiation firmware processor
`default_nettype none

module anx_apb_master (
    input wire logic clk_sys,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [31:0] prdata,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [9:0] paddr,
    output logic [31:0] pwdata
);
    timeunit 1ns;
    timeprecision 100ps;

    // =====================================================================
    // idle bus: released lines show the inverse, never a stale copy
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 10'h3ff;
        pwdata = 32'hffff_ffff;
    end

    // one setup and one access phase, held until pready is sampled high or 8 edges have passed
    task automatic xfer(input logic wr, input logic [9:0] a, input logic [31:0] d,
        output logic [31:0] q, output logic err);
        int n;
        @(posedge clk_sys);
        #1;
        psel = 1'b1;
        penable = 1'b0;
        pwrite = wr;
        paddr = a;
        pwdata = d;
        @(posedge clk_sys);
        #1;
        penable = 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 8);
        q = prdata;
        err = pslverr;
        #1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = ~wr;
        paddr = ~a;
        pwdata = ~d;
    endtask
endmodule

`default_nettype wire

// [tb.sv]
// self-checking bench for the negotiation transmit register bank
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 100ps;

    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic frame_sent = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, ext_access, ext_write, dp_reset;
    logic tx_ack_insert, link_disconnect, tengig_mode_select, pause_capable;
    logic [9:0] paddr;
    logic [31:0] pwdata, prdata, ext_wdata;
    logic [3:0] ext_group, ext_offset;
    logic [47:0] tx_page, page_exp;
    int miscompares = 0;
    int checked = 0;
    int cycles = 0;

    always #2 clk_sys = ~clk_sys;

    anx_apb_master u_mst (.clk_sys(clk_sys), .pready(pready), .pslverr(pslverr),
        .prdata(prdata), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata));

    anx_apb_regs u_dut (.clk_sys(clk_sys), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ext_access(ext_access), .ext_write(ext_write),
        .ext_group(ext_group), .ext_offset(ext_offset), .ext_wdata(ext_wdata),
        .frame_sent(frame_sent), .dp_reset(dp_reset), .tx_page(tx_page),
        .tx_ack_insert(tx_ack_insert), .link_disconnect(link_disconnect),
        .tengig_mode_select(tengig_mode_select), .pause_capable(pause_capable));

    // =====================================================================
    // shared helpers
    task automatic complete_run();
        $display("checked=%0d miscompares=%0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] o, input logic [7:0] d);
        logic [31:0] q;
        logic e;
        u_mst.xfer(1'b1, {4'h0, o, 2'b00}, {24'h0, d}, q, e);
    endtask

    task automatic rd(input logic [3:0] o, input logic [31:0] exp);
        logic [31:0] q;
        logic e;
        u_mst.xfer(1'b0, {4'h0, o, 2'b00}, 32'h0, q, e);
        chk(q, exp);
    endtask

    task automatic fsent();
        @(posedge clk_sys);
        #1 frame_sent = 1'b1;
        @(posedge clk_sys);
        #1 frame_sent = 1'b0;
    endtask

    // firmware polls the handoff flag before touching the page again
    task automatic wait_taken();
        logic [31:0] q;
        logic e;
        int n;
        n = 0;
        do begin
            u_mst.xfer(1'b0, 10'h000, 32'h0, q, e);
            n++;
        end while (q[0] !== 1'b0 && n < 10);
        chk(q[0], 1'b0);
    endtask

    // =====================================================================
    // scenarios
    task automatic t_reset();
        chk({dp_reset, link_disconnect, tengig_mode_select, pause_capable}, 4'h0);
        rd(4'h0, 32'h0);
        rd(4'h2, 32'h0);
    endtask

    task automatic t_cfg();
        wr(4'h2, 8'hff);
        rd(4'h2, 32'h85);
        chk({link_disconnect, tengig_mode_select, pause_capable}, 3'b111);
        wr(4'h3, 8'hff);
        rd(4'h3, 32'h0);
        wr(4'h0, 8'h7e);
        rd(4'h0, 32'h0);
        wr(4'h2, 8'h00);
        chk({link_disconnect, tengig_mode_select, pause_capable}, 3'b000);
    endtask

    task automatic t_page();
        for (int i = 0; i < 6; i++) begin
            page_exp[8*i +: 8] = 8'h3c ^ (8'h51 * i[7:0]);
            wr(4'h8 + i[3:0], page_exp[8*i +: 8]);
        end
        for (int i = 0; i < 6; i++) rd(4'h8 + i[3:0], {24'h0, page_exp[8*i +: 8]});
        wr(4'h0, 8'h01);
        wait_taken();
        chk(tx_page, page_exp);
    endtask

    // two written as the count gives three ack frames, then the bit drops
    task automatic t_ack();
        wr(4'h1, 8'h12);
        rd(4'h1, 32'h12);
        wr(4'h0, 8'h01);
        wait_taken();
        repeat (3) begin
            chk(tx_ack_insert, 1'b1);
            fsent();
        end
        chk(tx_ack_insert, 1'b0);
        rd(4'h1, 32'h02);
        wr(4'h1, 8'h10);
        fsent();
        chk(tx_ack_insert, 1'b0);
        wr(4'h1, 8'h00);
    endtask

    task automatic t_dp_reset();
        wr(4'h0, 8'h80);
        chk(dp_reset, 1'b1);
        rd(4'h0, 32'h80);
        wr(4'h8, 8'hff);
        wr(4'h0, 8'h81);
        repeat (4) @(posedge clk_sys);
        rd(4'h0, 32'h81);
        chk(tx_page, 48'h0);
        wr(4'h0, 8'h00);
        wait_taken();
        chk(tx_page, {page_exp[47:8], 8'hff});
        chk(dp_reset, 1'b0);
    endtask

    // every group code: write, then read back, error only off the map
    task automatic t_decode();
        logic [31:0] q;
        logic e;
        logic [3:0] g;
        for (int i = 0; i < 16; i++) begin
            g = i[3:0];
            u_mst.xfer(1'b1, {g, 4'h2, 2'b00}, 32'hff, q, e);
            chk(e, g inside {[4'h4:4'h7], [4'he:4'hf]});
            chk({ext_write, ext_wdata}, {1'b1, 32'hff});
            u_mst.xfer(1'b0, {g, 4'h2, 2'b00}, 32'h0, q, e);
            chk(q, (g == 4'h0) ? 32'h85 : 32'h0);
        end
    endtask

    // =====================================================================
    // hang guard and main sequence
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            complete_run();
        end
    end

    initial begin
        repeat (5) @(posedge clk_sys);
        #1 rstn = 1'b1;
        t_reset();
        t_cfg();
        t_page();
        t_ack();
        t_dp_reset();
        t_decode();
        complete_run();
    end
endmodule

`default_nettype wire
